// ===== pkg/ifsp_defs.vh
// Constants shared by the isolated fast serial port design.
`ifndef IFSP_DEFS_VH
`define IFSP_DEFS_VH
`define IFSP_WORD_BITS 8
`define IFSP_FIFO_DEPTH 16
`define IFSP_FIFO_PTR_BITS 4
`define IFSP_BIT_CNT_BITS 4
`define IFSP_TX_LAST_SLOT 4'h9
`define IFSP_RX_LAST_BIT 4'h7
`define IFSP_START_LEVEL 1'h0
`define IFSP_IDLE_LEVEL 1'h1
`define IFSP_LINK_CLK_IDLE 1'h1
`define IFSP_SYS_CLK_HZ 10000000
`define IFSP_LINK_MAX_BPS 12000000
`endif

// ===== verilog/ifsp_port.v
// Isolated fast serial port: transmit FIFO and four-wire link engine.
`timescale 1ns/10ps
`include "ifsp_defs.vh"

module ifsp_fifo #(
  parameter WIDTH = `IFSP_WORD_BITS,
  parameter DEPTH = `IFSP_FIFO_DEPTH,
  parameter PTR_BITS = `IFSP_FIFO_PTR_BITS
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Filling side
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output reg in_ready,
  // Draining side
  output wire [WIDTH-1:0] out_data,
  output reg out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [PTR_BITS-1:0] wr_ptr;
  reg [PTR_BITS-1:0] rd_ptr;
  reg [PTR_BITS:0] count;
  reg [PTR_BITS:0] next_count;
  wire push;
  wire pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // Read data is the array word itself; the engine copies it when it loads.
  assign out_data = mem[rd_ptr];

  // The count changes only when exactly one side moves.
  always @* begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // Flags are registered from the next count so both stay honest.
  always @(posedge clk) begin
    if (reset) begin
      wr_ptr <= {PTR_BITS{1'b0}};
      rd_ptr <= {PTR_BITS{1'b0}};
      count <= {(PTR_BITS+1){1'b0}};
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= next_count;
      in_ready <= (next_count != DEPTH[PTR_BITS:0]);
      out_valid <= (next_count != {(PTR_BITS+1){1'b0}});
    end
  end
endmodule // ifsp_fifo

module ifsp_port #(
  parameter WIDTH = `IFSP_WORD_BITS,
  parameter DEPTH = `IFSP_FIFO_DEPTH
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Words from the USB side toward the peripheral
  input wire [WIDTH-1:0] tx_data,
  input wire tx_valid,
  output wire tx_ready,
  // Words from the peripheral toward the USB side
  output reg [WIDTH-1:0] rx_data,
  output reg rx_valid,
  // Isolated link pins
  input wire iso_serial_in,
  input wire iso_link_clock,
  output reg iso_serial_out,
  output reg iso_clear_to_send_n,
  // Send-immediate and wakeup
  input wire send_now_wake_n,
  input wire power_enable_n,
  input wire remote_wake_enable,
  output reg resume_request,
  output reg flush_request
);
  localparam TX_IDLE = 2'b01;
  localparam TX_SEND = 2'b10;

  // Pointer width follows the depth, so a deeper buffer needs no edit.
  // The depth is expected to be a power of two.
  function integer ptr_width;
    input integer depth;
    integer n;
    begin
      ptr_width = 0;
      for (n = depth - 1; n > 0; n = n >> 1) begin
        ptr_width = ptr_width + 1;
      end
    end
  endfunction

  localparam PTR_BITS = ptr_width(DEPTH);

  // Stages two and three agree, so the pin has held for two samples.
  function settled;
    input [2:0] stages;
    begin
      settled = (stages[2] == stages[1]);
    end
  endfunction

  // A settled value that differs from the held level marks one edge.
  function edge_to;
    input [2:0] stages;
    input level;
    input target;
    begin
      edge_to = settled(stages) && (stages[2] == target) && (level != target);
    end
  endfunction

  // Three-stage synchronisers for every pin input.
  // Reset levels match the idle pins, so no false edge follows reset.
  reg [2:0] clk_sync;
  reg [2:0] din_sync;
  reg [2:0] wake_sync;
  reg [2:0] pwr_sync;
  reg clk_level;
  reg din_level;
  reg wake_level;
  reg pwr_level;
  reg [1:0] tx_state;
  reg [WIDTH-1:0] tx_shift;
  reg [`IFSP_BIT_CNT_BITS-1:0] tx_cnt;
  reg [WIDTH-1:0] rx_shift;
  reg [`IFSP_BIT_CNT_BITS-1:0] rx_cnt;
  reg rx_busy;
  reg fifo_pop;
  wire [WIDTH-1:0] fifo_data;
  wire fifo_valid;
  wire link_rise;
  wire link_fall;
  wire wake_strobe;

  ifsp_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH),
    .PTR_BITS(PTR_BITS)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_data(tx_data),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  // A change counts only once the second and third stages agree.
  always @(posedge clk) begin
    if (reset) begin
      clk_sync <= {3{`IFSP_LINK_CLK_IDLE}};
      din_sync <= 3'h7;
      wake_sync <= 3'h7;
      pwr_sync <= 3'h0;
      clk_level <= `IFSP_LINK_CLK_IDLE;
      din_level <= 1'b1;
      wake_level <= 1'b1;
      pwr_level <= 1'b0;
    end else begin
      clk_sync <= {clk_sync[1:0], iso_link_clock};
      din_sync <= {din_sync[1:0], iso_serial_in};
      wake_sync <= {wake_sync[1:0], send_now_wake_n};
      pwr_sync <= {pwr_sync[1:0], power_enable_n};
      if (settled(clk_sync)) begin
        clk_level <= clk_sync[2];
      end
      if (settled(din_sync)) begin
        din_level <= din_sync[2];
      end
      if (settled(wake_sync)) begin
        wake_level <= wake_sync[2];
      end
      if (settled(pwr_sync)) begin
        pwr_level <= pwr_sync[2];
      end
    end
  end

  // Link edges are found from the filtered link clock only.
  assign link_rise = edge_to(clk_sync, clk_level, 1'b1);
  assign link_fall = edge_to(clk_sync, clk_level, 1'b0);
  assign wake_strobe = edge_to(wake_sync, wake_level, 1'b0);

  // Data in is read from its settled level, steady by each rising edge.
  // Idle rising edges with data high are ignored, so stray clocks are safe.
  // Sampling at 10 MHz limits the link to about an eighth of that rate;
  // the full 12 Mbps needs a faster system clock with the same logic.
  always @(posedge clk) begin
    if (reset) begin
      rx_shift <= {WIDTH{1'b0}};
      rx_cnt <= {`IFSP_BIT_CNT_BITS{1'b0}};
      rx_busy <= 1'b0;
      rx_data <= {WIDTH{1'b0}};
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (link_rise) begin
        if (!rx_busy) begin
          if (din_level == `IFSP_START_LEVEL) begin
            rx_busy <= 1'b1;
            rx_cnt <= {`IFSP_BIT_CNT_BITS{1'b0}};
          end
        end else begin
          rx_shift <= {din_level, rx_shift[WIDTH-1:1]};
          rx_cnt <= rx_cnt + 1'b1;
          if (rx_cnt == `IFSP_RX_LAST_BIT) begin
            rx_busy <= 1'b0;
            rx_data <= {din_level, rx_shift[WIDTH-1:1]};
            rx_valid <= 1'b1;
          end
        end
      end
    end
  end

  // The engine waits on peripheral edges only, so any pacing up to about an eighth of the clock rate is safe.
  always @(posedge clk) begin
    if (reset) begin
      tx_state <= TX_IDLE;
      tx_shift <= {WIDTH{1'b0}};
      tx_cnt <= {`IFSP_BIT_CNT_BITS{1'b0}};
      fifo_pop <= 1'b0;
      iso_serial_out <= `IFSP_IDLE_LEVEL;
      iso_clear_to_send_n <= 1'b1;
    end else begin
      fifo_pop <= 1'b0;
      case (tx_state)
        TX_IDLE: begin
          // The pop is registered, so a stale valid must not load twice.
          if (fifo_valid && !fifo_pop) begin
            tx_shift <= fifo_data;
            tx_cnt <= {`IFSP_BIT_CNT_BITS{1'b0}};
            fifo_pop <= 1'b1;
            iso_clear_to_send_n <= 1'b0;
            tx_state <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (link_fall) begin
            tx_cnt <= tx_cnt + 1'b1;
            if (tx_cnt == {`IFSP_BIT_CNT_BITS{1'b0}}) begin
              iso_serial_out <= `IFSP_START_LEVEL;
            end else if (tx_cnt != `IFSP_TX_LAST_SLOT) begin
              iso_serial_out <= tx_shift[0];
              tx_shift <= {1'b0, tx_shift[WIDTH-1:1]};
            end else begin
              // The tenth falling edge returns the line to idle.
              iso_serial_out <= `IFSP_IDLE_LEVEL;
              iso_clear_to_send_n <= 1'b1;
              tx_state <= TX_IDLE;
            end
          end
        end
        default: begin
          tx_state <= TX_IDLE;
        end
      endcase
    end
  end

  // A held-high strobe input never produces an event.
  // Both requests are single pulses; the strobe must go high to repeat.
  always @(posedge clk) begin
    if (reset) begin
      resume_request <= 1'b0;
      flush_request <= 1'b0;
    end else begin
      resume_request <= wake_strobe && pwr_level && remote_wake_enable;
      flush_request <= wake_strobe && !pwr_level;
    end
  end
endmodule // ifsp_port

// ===== dv/ifsp_checker.sv
// Port checker for the isolated fast serial port.
`timescale 1ns/10ps
module ifsp_checker (
  // Watched ports
  input wire clk,
  input wire reset,
  input wire tx_valid,
  input wire tx_ready,
  input wire iso_link_clock,
  input wire iso_serial_out,
  input wire iso_clear_to_send_n,
  input wire send_now_wake_n,
  input wire power_enable_n,
  input wire remote_wake_enable,
  input wire resume_request,
  input wire flush_request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Cycles since the link clock pin fell; the filter adds a few.
  logic [3:0] since_fall;
  logic lclk_d;
  always @(posedge clk) begin
    lclk_d <= iso_link_clock;
    if (reset) since_fall <= 4'hf;
    else if (lclk_d && !iso_link_clock) since_fall <= 4'h0;
    else if (since_fall != 4'hf) since_fall <= since_fall + 4'h1;
  end
  a_out_on_fall: assert property ($changed(iso_serial_out) |->
    since_fall inside {[4'h1:4'h6]}) else $error("data out moved off edge");
  a_start_under_cts: assert property ($fell(iso_serial_out) |->
    !iso_clear_to_send_n) else $error("data low without cts");
  a_cts_end_idle: assert property ($rose(iso_clear_to_send_n) |->
    iso_serial_out) else $error("cts rose mid frame");
  a_load_cts: assert property (tx_valid && tx_ready &&
    iso_clear_to_send_n |-> ##[1:4] !iso_clear_to_send_n)
    else $error("cts not low after load");
  a_wake_resume: assert property ($fell(send_now_wake_n) &&
    power_enable_n && remote_wake_enable |-> ##[2:8] resume_request)
    else $error("no resume");
  a_wake_flush: assert property ($fell(send_now_wake_n) &&
    !power_enable_n |-> ##[2:8] flush_request) else $error("no flush");
  a_resume_gated: assert property (resume_request |->
    power_enable_n && remote_wake_enable) else $error("stray resume");
  a_flush_gated: assert property (flush_request |->
    !power_enable_n) else $error("stray flush");
  cover property (resume_request);
  cover property (flush_request);
  cover property (tx_valid && tx_ready);
endmodule // ifsp_checker
bind ifsp_port ifsp_checker i_chk (
  .clk(clk),
  .reset(reset),
  .tx_valid(tx_valid),
  .tx_ready(tx_ready),
  .iso_link_clock(iso_link_clock),
  .iso_serial_out(iso_serial_out),
  .iso_clear_to_send_n(iso_clear_to_send_n),
  .send_now_wake_n(send_now_wake_n),
  .power_enable_n(power_enable_n),
  .remote_wake_enable(remote_wake_enable),
  .resume_request(resume_request),
  .flush_request(flush_request)
);

// ===== dv/ifsp_peer.sv
// Behavioural peripheral that paces the isolated link.
`timescale 1ns/10ps
module ifsp_peer (
  // Link pins seen from the peripheral
  output logic link_clock,
  output logic serial_in,
  input wire serial_out
);
  // Clock stands high between frames; data idles high.
  initial begin
    link_clock = 1'h1;
    serial_in = 1'h1;
  end
  task automatic xfer(input logic [7:0] d, input int half,
    output logic [7:0] q);
    logic [9:0] f;
    f = {1'h1, d, 1'h0};
    for (int k = 0; k < 10; k++) begin
      #half link_clock = 1'h0;
      serial_in = f[k];
      #half link_clock = 1'h1;
      if (k > 0 && k < 9) q[k-1] = serial_out;
    end
  endtask
endmodule // ifsp_peer

// ===== dv/ifsp_port_tb.sv
// Self-checking bench for the isolated fast serial port.
`timescale 1ns/10ps
module ifsp_port_tb;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic [7:0] tx_data = 8'h00;
  logic tx_valid = 1'h0;
  logic wake_n = 1'h1;
  logic pwr_n = 1'h0;
  logic rwe = 1'h0;
  logic tx_ready, rx_valid, sout, cts_n, lclk, sin, res, fl;
  logic [7:0] rx_data;
  int n_errors = 0;
  int compares = 0;
  int n_res = 0;
  int n_fl = 0;
  logic [7:0] rxq[$];
  logic [7:0] txq[$];
  ifsp_port i_dut (.clk(clk), .reset(reset), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .iso_serial_in(sin), .iso_link_clock(lclk),
    .iso_serial_out(sout), .iso_clear_to_send_n(cts_n),
    .send_now_wake_n(wake_n), .power_enable_n(pwr_n),
    .remote_wake_enable(rwe), .resume_request(res), .flush_request(fl));
  ifsp_peer i_peer (.link_clock(lclk), .serial_in(sin), .serial_out(sout));
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    if (rx_valid === 1'h1) rxq.push_back(rx_data);
    if (res === 1'h1) n_res++;
    if (fl === 1'h1) n_fl++;
  end
  task automatic chk(input string s, input logic [7:0] e, g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wt_cts;
    int i;
    for (i = 0; i < 60 && cts_n !== 1'h0; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 60) begin
      n_errors++;
      report_and_stop();
    end
  endtask
  // Fill with the link stalled, then drain at two pacings.
  task automatic t_fill_drain;
    logic [7:0] q;
    for (int i = 0; i < 30; i++) begin
      tx_data = 8'ha0 + 8'(i);
      tx_valid = 1'h1;
      if (tx_ready === 1'h1) txq.push_back(tx_data);
      @(posedge clk);
      #1;
    end
    tx_valid = 1'h0;
    chk("tx_ready full", 8'h00, tx_ready);
    for (int k = 0; txq.size() > 0; k++) begin
      wt_cts();
      i_peer.xfer(8'h5a ^ 8'(k), (k % 2) ? 1300 : 400, q);
      chk("word out", txq.pop_front(), q);
      chk("word in", 8'h5a ^ 8'(k), rxq.pop_front());
    end
    repeat (10) @(posedge clk);
    chk("cts idle", 8'h01, cts_n);
    chk("rx extra", 8'h00, 8'(rxq.size()));
  endtask
  // A wake strobe in one mode; pulse counts are compared.
  task automatic t_wake(input logic p, r, input logic [7:0] er, ef);
    int r0, f0;
    r0 = n_res;
    f0 = n_fl;
    pwr_n = p;
    rwe = r;
    repeat (8) @(posedge clk);
    #1 wake_n = 1'h0;
    repeat (5) @(posedge clk);
    #1 wake_n = 1'h1;
    repeat (12) @(posedge clk);
    chk("resume", er, 8'(n_res - r0));
    chk("flush", ef, 8'(n_fl - f0));
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1 reset = 1'h0;
    repeat (2) @(posedge clk);
    #1;
    t_fill_drain();
    t_wake(1'h1, 1'h1, 8'h01, 8'h00);
    t_wake(1'h1, 1'h0, 8'h00, 8'h00);
    t_wake(1'h0, 1'h1, 8'h00, 8'h01);
    report_and_stop();
  end
endmodule // ifsp_port_tb
